// ==== hdl/gses_seq.v ====
`timescale 1ns/1ps
`include "gses_defs.vh"

module gses_seq #(
    parameter [31:0] ROW_CLKS   = `GSES_ROW_CLKS,
    parameter [11:0] FRAME_ROWS = `GSES_FRAME_ROWS
) (
    input  wire        core_clk_i,
    input  wire        nrst_i,
    input  wire        start_i,
    input  wire        stop_i,
    input  wire        overlap_en_i,
    input  wire [31:0] exp_clks_i,
    input  wire [31:0] cycle_rows_i,
    input  wire [11:0] frame_rows_i,
    output reg         drain_o,
    output reg         xfer_o,
    output reg         exposure_indicator_out_o,
    output reg         all_rows_exposing_out_o,
    output reg         any_row_exposing_out_o,
    output reg         row_n_exposing_out_o,
    output wire        trigger_ready_o,
    output reg         ref_rd_o,
    output reg         sig_rd_o,
    output reg         row_strobe_o,
    output reg         busy_o,
    output reg  [31:0] exp_rows_o
);

    // derived limits; longest times round down, least times round up
    localparam [63:0] ROW_NS       = {32'h0, ROW_CLKS} * `GSES_CLK_NS;
    localparam [63:0] EXP_MAX_64   = `GSES_EXP_MAX_NS / ROW_NS;
    localparam [63:0] CYC_MAX_64   = `GSES_CYC_MAX_NS / ROW_NS;
    localparam [63:0] XFER_64      = (`GSES_XFER_NS + `GSES_CLK_NS
                                      - 64'h1) / `GSES_CLK_NS;
    // short rows push the 20000 s limit past 32 bits, so saturate
    localparam [31:0] EXP_MAX_ROWS = (EXP_MAX_64 > 64'hFFFFFFFF) ?
                                     32'hFFFFFFFF : EXP_MAX_64[31:0];
    localparam [31:0] CYC_MAX_ROWS = (CYC_MAX_64 > 64'hFFFFFFFF) ?
                                     32'hFFFFFFFF : CYC_MAX_64[31:0];
    localparam [15:0] XFER_CLKS    = XFER_64[15:0];
    localparam [31:0] G            = `GSES_IFG_ROWS;

    reg  [1:0]  st_ff;          // sequencer state
    reg  [1:0]  nxt_st;         // next state
    reg  [31:0] row_div_ff;     // clock count within the current row
    reg  [31:0] cyc_ff;         // row index within the current image cycle
    reg  [31:0] e_ff;           // quantised exposure, rows
    reg  [31:0] f_ff;           // frame length, rows
    reg  [31:0] cyc_cfg_ff;     // requested long cycle time, rows
    reg         ovl_ff;         // overlap mode latched at start
    reg         run_req_ff;     // keep starting images while set
    reg  [31:0] sig_cnt_ff;     // rows left in the signal readout
    reg         sig_act_ff;     // signal readout in progress
    reg  [15:0] xfer_cnt_ff;    // clocks left of the transfer pulse
    reg         exp_d_ff;       // exposing, delayed one clock
    reg         rnd_go_ff;      // starts the rounding divider
    wire        rnd_done;       // rounding finished
    wire [31:0] rnd_rows;       // rounded exposure rows
    wire        running;        // image cycle counter active
    wire        row_tick;       // last clock of a row period
    wire [31:0] cyc_nxt;        // cycle row after this tick
    wire        cyc_end;        // last row of the image cycle
    wire        short_seq;      // short non-overlap sequence chosen
    wire [31:0] es_w;           // exposure start row
    wire [31:0] rs_w;           // reference readout start row
    wire [31:0] ss_w;           // signal readout start row
    wire [31:0] t_long_min;     // long sequence least cycle
    wire [31:0] t_long;         // long sequence cycle after limits
    wire [31:0] t_ovl_fix;      // overlap cycle, mid exposure range
    wire [31:0] t_ovl_var;      // overlap cycle, long exposures
    wire [31:0] t_w;            // cycle length in rows
    wire        exposing;       // global exposure window
    wire        ref_win;        // reference readout window
    wire [31:0] f_cfg;          // frame input limited to the array
    reg  [31:0] e_lim;          // exposure after range limits
    wire [31:0] ovl_min;        // least exposure in overlap mode

    gses_rounder #(
        .DIV        (ROW_CLKS)
    ) u_round (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .go_i       (rnd_go_ff),
        .clks_i     (exp_clks_i),
        .done_o     (rnd_done),
        .rows_o     (rnd_rows)
    );

    // frame height follows the half-sensor region of interest
    assign f_cfg = (frame_rows_i == 12'h0) ? 32'h1 :
                   (frame_rows_i > FRAME_ROWS) ? {20'h0, FRAME_ROWS} :
                   {20'h0, frame_rows_i};
    assign ovl_min = f_cfg + G + `GSES_OVL_ROW;

    // exposure limits: one row up to 30 s; overlap needs a frame+gap+row
    always @*
    begin
        e_lim = rnd_rows;
        if (e_lim == 32'h0)
            e_lim = 32'h1;
        if (e_lim > EXP_MAX_ROWS)
            e_lim = EXP_MAX_ROWS;
        if (overlap_en_i && (e_lim < ovl_min))
            e_lim = ovl_min;
    end

    // row period divider; every row is ROW_CLKS clocks
    assign running  = (st_ff == `GSES_ST_RUN);
    assign row_tick = (row_div_ff == ROW_CLKS - 32'h1);
    assign cyc_end  = (cyc_ff == t_w - 32'h1);
    assign cyc_nxt  = cyc_end ? 32'h0 : cyc_ff + 32'h1;

    // sequence choice by exposure against frame length
    assign short_seq = !ovl_ff &&
                       (e_ff <= f_ff + `GSES_SHORT_EXTRA);
    // short: ref at 0, expose after it, gap, signal, gap
    // long/overlap: drain at 0, ref ends at exposure end, gap, signal
    assign es_w = short_seq ? f_ff : 32'h0;
    assign rs_w = short_seq ? 32'h0 : e_ff - f_ff;
    assign ss_w = e_ff + G + (short_seq ? f_ff : 32'h0);
    assign t_long_min = e_ff + f_ff + G + `GSES_LONG_TAIL;
    assign t_long = (cyc_cfg_ff > CYC_MAX_ROWS) ? CYC_MAX_ROWS :
                    (cyc_cfg_ff > t_long_min) ? cyc_cfg_ff :
                    t_long_min;
    assign t_ovl_fix = f_ff + f_ff + G + G + `GSES_OVL_ROW;
    assign t_ovl_var = e_ff + G + `GSES_OVL_ROW;
    assign t_w = ovl_ff ? ((t_ovl_var > t_ovl_fix) ? t_ovl_var
                                                   : t_ovl_fix) :
                 short_seq ? (f_ff + f_ff + G + G + e_ff) :
                 t_long;

    // windows in row units; both frames read for each image
    assign exposing = running && (cyc_ff >= es_w) &&
                      (cyc_ff < es_w + e_ff);
    assign ref_win  = running && (cyc_ff >= rs_w) &&
                      (cyc_ff < rs_w + f_ff);

    // internal triggering only, so no external trigger is ever awaited
    assign trigger_ready_o = 1'b0;

    // state sequencing
    always @*
    begin
        nxt_st = st_ff;
        case (st_ff)
            `GSES_ST_IDLE:
                // a host start is refused while a signal readout drains
                if (start_i && !sig_act_ff)
                    nxt_st = `GSES_ST_ROUND;
            `GSES_ST_ROUND:
                if (rnd_done)
                    nxt_st = `GSES_ST_LOAD;
            `GSES_ST_LOAD:
                nxt_st = `GSES_ST_RUN;
            `GSES_ST_RUN:
                // images always run to their cycle end
                if (row_tick && cyc_end && !run_req_ff)
                    nxt_st = `GSES_ST_IDLE;
            default:
                nxt_st = `GSES_ST_IDLE;
        endcase
    end

    // state, configuration capture and stop request
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            st_ff      <= `GSES_ST_IDLE;
            rnd_go_ff  <= 1'b0;
            run_req_ff <= 1'b0;
            e_ff       <= 32'h1;
            f_ff       <= {20'h0, FRAME_ROWS};
            cyc_cfg_ff <= 32'h0;
            ovl_ff     <= 1'b0;
        end
        else
        begin
            st_ff     <= nxt_st;
            rnd_go_ff <= (st_ff == `GSES_ST_IDLE) &&
                         (nxt_st == `GSES_ST_ROUND);
            if (st_ff == `GSES_ST_IDLE)
                run_req_ff <= 1'b1;
            else if (stop_i)
                run_req_ff <= 1'b0;
            // settings are frozen for the whole acquisition
            if ((st_ff == `GSES_ST_ROUND) && rnd_done)
            begin
                e_ff       <= e_lim;
                f_ff       <= f_cfg;
                cyc_cfg_ff <= cycle_rows_i;
                ovl_ff     <= overlap_en_i;
            end
        end
    end

    // row divider and image cycle counter; divider restarts on load so
    // the first image begins with no start delay
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            row_div_ff <= 32'h0;
            cyc_ff     <= 32'h0;
        end
        else
        begin
            if (st_ff == `GSES_ST_LOAD)
                row_div_ff <= 32'h0;
            else if (running || sig_act_ff)
                row_div_ff <= row_tick ? 32'h0 : row_div_ff + 32'h1;
            if (st_ff == `GSES_ST_LOAD)
                cyc_ff <= 32'h0;
            else if (running && row_tick)
                cyc_ff <= cyc_nxt;
        end
    end

    // signal readout runs on its own counter, so in overlap it carries
    // on past the next image start while the next exposure begins
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            sig_cnt_ff <= 32'h0;
            sig_act_ff <= 1'b0;
        end
        else if (row_tick)
        begin
            if (running && (cyc_nxt == ss_w) && !cyc_end)
            begin
                sig_cnt_ff <= f_ff;
                sig_act_ff <= 1'b1;
            end
            else if (sig_act_ff)
            begin
                sig_cnt_ff <= sig_cnt_ff - 32'h1;
                sig_act_ff <= (sig_cnt_ff != 32'h1);
            end
        end
    end

    // charge transfer pulse fires as the exposure window closes; it
    // fits inside the gap rows, well before the signal readout
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            exp_d_ff    <= 1'b0;
            xfer_cnt_ff <= 16'h0;
        end
        else
        begin
            exp_d_ff <= exposing;
            if (exp_d_ff && !exposing)
                xfer_cnt_ff <= XFER_CLKS;
            else if (xfer_cnt_ff != 16'h0)
                xfer_cnt_ff <= xfer_cnt_ff - 16'h1;
        end
    end

    // registered outputs toward the sensor and the host
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            drain_o                  <= 1'b1;
            xfer_o                   <= 1'b0;
            exposure_indicator_out_o <= 1'b0;
            all_rows_exposing_out_o  <= 1'b0;
            any_row_exposing_out_o   <= 1'b0;
            row_n_exposing_out_o     <= 1'b0;
            ref_rd_o                 <= 1'b0;
            sig_rd_o                 <= 1'b0;
            row_strobe_o             <= 1'b0;
            busy_o                   <= 1'b0;
            exp_rows_o               <= 32'h0;
        end
        else
        begin
            // pixels held drained except while integrating or moving
            // charge, so its falling edge is the exposure start
            drain_o <= !(exposing || (exp_d_ff && !exposing) ||
                         (xfer_cnt_ff > 16'h1));
            xfer_o  <= (exp_d_ff && !exposing) ||
                       (xfer_cnt_ff > 16'h1);
            exposure_indicator_out_o <= exposing;
            all_rows_exposing_out_o  <= exposing;
            any_row_exposing_out_o   <= exposing;
            row_n_exposing_out_o     <= exposing;
            ref_rd_o     <= ref_win;
            sig_rd_o     <= sig_act_ff;
            row_strobe_o <= row_tick && (running || sig_act_ff);
            busy_o       <= (nxt_st != `GSES_ST_IDLE) || sig_act_ff;
            exp_rows_o   <= e_ff;
        end
    end

endmodule

// ==== hdl/gses_defs.vh ====
`ifndef GSES_DEFS_VH
`define GSES_DEFS_VH

// sensor readout clock cycles in one row period
`define GSES_ROW_CLKS        32'hA40
// core clock period in ns (50 MHz)
`define GSES_CLK_NS          64'h14
// full-frame height of one sensor half, in rows
`define GSES_FRAME_ROWS      12'h438
// interframe gap between reference and signal readouts, in rows
`define GSES_IFG_ROWS        32'h9
// short sequence allowed up to one frame plus this many rows
`define GSES_SHORT_EXTRA     32'h3
// tail rows after the signal readout in the long sequence
`define GSES_LONG_TAIL       32'h6
// extra row in the overlap cycle time
`define GSES_OVL_ROW         32'h1
// least charge transfer pulse width in ns
`define GSES_XFER_NS         64'h157C
// longest exposure, 30 s, in ns
`define GSES_EXP_MAX_NS      64'h6FC23AC00
// longest cycle time, 20000 s, in ns
`define GSES_CYC_MAX_NS      64'h12309CE54000

// sequencer states
`define GSES_ST_IDLE         2'h0
`define GSES_ST_ROUND        2'h1
`define GSES_ST_LOAD         2'h2
`define GSES_ST_RUN          2'h3

`endif

// ==== hdl/gses_rounder.v ====
`timescale 1ns/1ps
`include "gses_defs.vh"

// converts a requested exposure in clocks to the nearest whole row count
// by a 33-step restoring divide; finishes well inside one row period
module gses_rounder #(
    parameter [31:0] DIV = `GSES_ROW_CLKS
) (
    input  wire        core_clk_i,
    input  wire        nrst_i,
    input  wire        go_i,
    input  wire [31:0] clks_i,
    output reg         done_o,
    output wire [31:0] rows_o
);

    reg  [32:0] num_ff;     // dividend shifting out, quotient shifting in
    reg  [32:0] rem_ff;     // partial remainder, always below DIV
    reg  [5:0]  cnt_ff;     // remaining divide steps
    wire [32:0] rem_sh;     // remainder with next dividend bit
    wire        fits;       // divisor fits into shifted remainder

    assign rem_sh = {rem_ff[31:0], num_ff[32]};
    assign fits   = (rem_sh >= {1'b0, DIV});
    assign rows_o = num_ff[31:0];

    // half a divisor is added first, so truncation becomes rounding
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            num_ff <= 33'h0;
            rem_ff <= 33'h0;
            cnt_ff <= 6'h0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (go_i)
            begin
                num_ff <= {1'b0, clks_i} + {2'h0, DIV[31:1]};
                rem_ff <= 33'h0;
                cnt_ff <= 6'h21;
            end
            else if (cnt_ff != 6'h0)
            begin
                // one quotient bit per cycle
                rem_ff <= fits ? (rem_sh - {1'b0, DIV}) : rem_sh;
                num_ff <= {num_ff[31:0], fits};
                cnt_ff <= cnt_ff - 6'h1;
                done_o <= (cnt_ff == 6'h1);
            end
        end
    end

endmodule

// ==== bench/gses_seq_checker.sv ====
`timescale 1ns/1ps
`include "gses_defs.vh"

// port-level watch on the sequencer; counters hold widths and gaps
module gses_seq_checker #(
    parameter [31:0] ROW_CLKS = `GSES_ROW_CLKS
) (
    input wire        core_clk_i,
    input wire        nrst_i,
    input wire        start_i,
    input wire        drain_o,
    input wire        xfer_o,
    input wire        exposure_indicator_out_o,
    input wire        all_rows_exposing_out_o,
    input wire        any_row_exposing_out_o,
    input wire        row_n_exposing_out_o,
    input wire        trigger_ready_o,
    input wire        ref_rd_o,
    input wire        sig_rd_o,
    input wire        busy_o,
    input wire [31:0] exp_rows_o
);
    reg [31:0] gap_ff;   // cycles since the reference readout ended
    reg [31:0] xw_ff;    // transfer pulse width so far
    reg [31:0] ew_ff;    // exposure width so far

    // gap saturates so a long idle never wraps back below the limit
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            gap_ff <= 32'h0;
            xw_ff  <= 32'h0;
            ew_ff  <= 32'h0;
        end
        else
        begin
            gap_ff <= ref_rd_o ? 32'h0 :
                      (&gap_ff ? gap_ff : gap_ff + 32'h1);
            xw_ff  <= xfer_o ? xw_ff + 32'h1 : 32'h0;
            ew_ff  <= exposure_indicator_out_o ? ew_ff + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    chk_ind_mirror: assert property (all_rows_exposing_out_o ==
        exposure_indicator_out_o && any_row_exposing_out_o ==
        exposure_indicator_out_o && row_n_exposing_out_o ==
        exposure_indicator_out_o) else $error("indicators differ");
    chk_trig_idle: assert property (!trigger_ready_o)
        else $error("trigger ready raised");
    chk_drain_open: assert property (exposure_indicator_out_o
        |-> !drain_o) else $error("drain high in exposure");
    chk_exp_start: assert property ($rose(exposure_indicator_out_o)
        |-> $fell(drain_o)) else $error("exposure not at drain fall");
    chk_xfer_end: assert property ($fell(exposure_indicator_out_o)
        |-> $rose(xfer_o)) else $error("no transfer at exposure end");
    chk_xfer_width: assert property ($fell(xfer_o)
        |-> xw_ff == 32'h113) else $error("transfer width wrong");
    chk_exp_width: assert property ($fell(exposure_indicator_out_o)
        |-> ew_ff == exp_rows_o * ROW_CLKS) else $error("exposure width");
    chk_frame_excl: assert property (!(ref_rd_o && sig_rd_o))
        else $error("both readouts flagged");
    chk_gap_rows: assert property ($rose(sig_rd_o)
        |-> gap_ff >= `GSES_IFG_ROWS * ROW_CLKS) else $error("gap short");
    chk_start_busy: assert property (start_i && !busy_o
        |=> busy_o) else $error("start not taken");
endmodule

bind gses_seq gses_seq_checker #(.ROW_CLKS(ROW_CLKS)) u_chk (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .start_i(start_i),
    .drain_o(drain_o), .xfer_o(xfer_o),
    .exposure_indicator_out_o(exposure_indicator_out_o),
    .all_rows_exposing_out_o(all_rows_exposing_out_o),
    .any_row_exposing_out_o(any_row_exposing_out_o),
    .row_n_exposing_out_o(row_n_exposing_out_o),
    .trigger_ready_o(trigger_ready_o), .ref_rd_o(ref_rd_o),
    .sig_rd_o(sig_rd_o), .busy_o(busy_o), .exp_rows_o(exp_rows_o));

// ==== bench/gses_host.sv ====
`timescale 1ns/1ps

// host software side: one start command per request level rise
module gses_host (
    input  wire core_clk_i,
    input  wire go_i,
    output reg  start_o = 1'b0
);
    reg go_ff = 1'b0;   // last request level seen

    // pulse is one clock wide; a held request never repeats it
    always @(negedge core_clk_i)
    begin
        start_o <= go_i & ~go_ff;
        go_ff   <= go_i;
    end
endmodule

// ==== bench/gses_seq_tb.sv ====
`timescale 1ns/1ps
`include "gses_defs.vh"

module gses_seq_tb;
    localparam [31:0] RC = 32'h28;   // short rows keep the run brief
    localparam [31:0] FR = 32'h4;    // frame height in rows
    localparam [31:0] G  = `GSES_IFG_ROWS;
    reg         core_clk_i = 1'b0;
    reg         nrst_i     = 1'b0;
    reg         go         = 1'b0;   // request to the host model
    reg         stop       = 1'b0;
    reg         ovl        = 1'b0;
    reg  [31:0] exp_c      = 32'h0;
    reg  [31:0] cyc_r      = 32'h0;
    wire        start, drain, xfer, ind, ind_a, ind_y, ind_r, rdy;
    wire        ref_rd, sig_rd, busy, rs;
    reg  [11:0] fr         = FR[11:0];   // frame height request
    wire [31:0] rows;
    integer     n_fail = 0, comparisons = 0, cyc = 0;
    integer     t_ref, t_reff, t_exp, t_expf, t_sig, t_exp1;
    integer     n_row;                   // row strobes in this run
    reg         sig_at1, p_ref = 1'b0, p_exp = 1'b0, p_sig = 1'b0;

    always #10 core_clk_i = ~core_clk_i;

    gses_host host (.core_clk_i(core_clk_i), .go_i(go), .start_o(start));

    gses_seq #(.ROW_CLKS(RC), .FRAME_ROWS(FR[11:0])) dut (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .start_i(start),
        .stop_i(stop), .overlap_en_i(ovl), .exp_clks_i(exp_c),
        .cycle_rows_i(cyc_r), .frame_rows_i(fr), .drain_o(drain),
        .xfer_o(xfer), .exposure_indicator_out_o(ind),
        .all_rows_exposing_out_o(ind_a), .any_row_exposing_out_o(ind_y),
        .row_n_exposing_out_o(ind_r), .trigger_ready_o(rdy),
        .ref_rd_o(ref_rd), .sig_rd_o(sig_rd), .row_strobe_o(rs),
        .busy_o(busy), .exp_rows_o(rows));

    task end_sim;
    begin
        $display("fails %0d of %0d compares", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask

    // edge times of the first image and the next exposure; hang guard
    always @(posedge core_clk_i)
    begin
        cyc = cyc + 1;
        if (rs) n_row = n_row + 1;
        if (ref_rd && !p_ref && t_ref < 0) t_ref = cyc;
        if (!ref_rd && p_ref && t_reff < 0) t_reff = cyc;
        if (ind && !p_exp && t_exp >= 0 && t_exp1 < 0)
        begin
            t_exp1  = cyc;
            sig_at1 = sig_rd;
        end
        if (ind && !p_exp && t_exp < 0) t_exp = cyc;
        if (!ind && p_exp && t_expf < 0) t_expf = cyc;
        if (sig_rd && !p_sig && t_sig < 0) t_sig = cyc;
        p_ref = ref_rd;
        p_exp = ind;
        p_sig = sig_rd;
        if (cyc >= 40000)
        begin
            n_fail = n_fail + 1;
            end_sim;
        end
    end

    task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            n_fail = n_fail + 1;
            $display("MISMATCH %s exp %0d got %0d", nm, e, g);
        end
    end
    endtask

    // one acquisition: start, stop once the second exposure begins, drain out
    task run(input [31:0] ec, input [31:0] cr, input o);
        integer k;
    begin
        t_ref = -1; t_reff = -1; t_exp = -1;
        n_row = 0;
        t_expf = -1; t_sig = -1; t_exp1 = -1;
        exp_c <= ec;
        cyc_r <= cr;
        ovl   <= o;
        go    <= 1'b1;
        repeat (2) @(negedge core_clk_i);
        go <= 1'b0;
        for (k = 0; k < 9000 && t_exp1 < 0; k = k + 1)
            @(negedge core_clk_i);
        stop <= 1'b1;
        @(negedge core_clk_i);
        stop <= 1'b0;
        for (k = 0; k < 9000 && busy !== 1'b0; k = k + 1)
            @(negedge core_clk_i);
        // one more cycle so the last registered row strobe is counted;
        // a sequencer stuck busy must not slip through to the verdict
        @(negedge core_clk_i);
        chk("idle", 32'h0, {31'h0, busy});
    end
    endtask

    task t_reset;
    begin
        chk("drain", 32'h1, {31'h0, drain});
        chk("indicator", 32'h0, {31'h0, ind});
        chk("busy", 32'h0, {31'h0, busy});
        chk("ready", 32'h0, {31'h0, rdy});
    end
    endtask

    // largest short exposure, rounded down from 7.475 rows
    task t_short;
    begin
        run(32'h12B, 32'h0, 1'b0);
        chk("rows", 32'h7, rows);
        chk("ref_to_exp", FR * RC, t_exp - t_ref);
        chk("exp_len", 32'h7 * RC, t_expf - t_exp);
        chk("ref_to_sig", (FR + 32'h7 + G) * RC, t_sig - t_ref);
        chk("cycle", (32'h2 * FR + 32'h2 * G + 32'h7) * RC,
            t_exp1 - t_exp);
        chk("strobes", 32'h4 * FR + 32'h4 * G + 32'hE, n_row);
        // a zero request becomes the one-row least exposure
        run(32'h0, 32'h0, 1'b0);
        chk("rows", 32'h1, rows);
        chk("ref_to_exp", FR * RC, t_exp - t_ref);
        chk("exp_len", RC, t_expf - t_exp);
        chk("cycle", (32'h2 * FR + 32'h2 * G + 32'h1) * RC,
            t_exp1 - t_exp);
    end
    endtask

    // smallest long exposure, 7.5 rows rounded half up
    task t_long;
    begin
        // frame request above the array height is held to the array
        fr <= 12'h9;
        run(32'h12C, 32'h0, 1'b0);
        fr <= FR[11:0];
        chk("rows", 32'h8, rows);
        chk("exp_to_ref", (32'h8 - FR) * RC, t_ref - t_exp);
        chk("ref_end", 32'h8 * RC, t_reff - t_exp);
        chk("exp_to_sig", (32'h8 + G) * RC, t_sig - t_exp);
        chk("cycle", (32'h8 + FR + G + 32'h6) * RC, t_exp1 - t_exp);
    end
    endtask

    // requested cycle above the minimum wins
    task t_cap;
    begin
        run(32'h8 * RC, 32'h28, 1'b0);
        chk("cycle", 32'h28 * RC, t_exp1 - t_exp);
    end
    endtask

    // overlap fixed band, then exposure-led band
    task t_ovl;
    begin
        run(32'hE * RC, 32'h0, 1'b1);
        chk("cycle", (32'h2 * FR + 32'h2 * G + 32'h1) * RC,
            t_exp1 - t_exp);
        run(32'h30D, 32'h0, 1'b1);
        chk("rows", 32'h14, rows);
        chk("cycle", (32'h14 + G + 32'h1) * RC, t_exp1 - t_exp);
        chk("sig_busy", 32'h1, {31'h0, sig_at1});
    end
    endtask

    initial
    begin
        repeat (3) @(negedge core_clk_i);
        nrst_i <= 1'b1;
        @(negedge core_clk_i);
        t_reset;
        t_short;
        t_long;
        t_cap;
        t_ovl;
        end_sim;
    end
endmodule
